// >>> design/dar_pkg.sv
// Constants shared by the dual converter readout block.
// Assumes a single 40 MHz system clock; no bus, config bits arrive as ports.
package dar_pkg;
  localparam int CLK_PERIOD_NS = 25;
  localparam int CONV_TIME_NS = 650; // Longest conversion time
  localparam int CONV_CYC = (CONV_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RES_W = 16;
  localparam int IN_W = 17; // Input level in steps of reference / 2^16
  localparam int LVL_W = 10;
  localparam int DUAL_BITS = 16;
  localparam int SINGLE_BITS = 32;
  localparam logic [15:0] CODE_MID = 16'h8000;
  localparam logic [15:0] CODE_MAX = 16'hFFFF;
  localparam logic [15:0] CODE_MIN = 16'h0000;
  localparam logic REF_SRC_RST = 1'b0;
  localparam logic [5:0] CNT_RST = 6'h00;
  typedef enum logic [0:0] {
    DAR_IDLE = 1'b0,
    DAR_CONV = 1'b1
  } dar_state_t;
endpackage : dar_pkg

// >>> design/dar_sh_if.sv
// Signals between the frame control and the output shifter.
// Assumes both ends sit on the same clock.
`timescale 1ns/1ps
`default_nettype none
interface dar_sh_if;
  logic load;
  logic start;
  logic shift;
  logic single;
  logic [15:0] word_a;
  logic [15:0] word_b;
  logic dout_a;
  logic dout_b;
  modport ctl (output load, output start, output shift, output single, output word_a, output word_b,
    input dout_a, input dout_b);
  modport shf (input load, input start, input shift, input single, input word_a, input word_b,
    output dout_a, output dout_b);
endinterface : dar_sh_if
`default_nettype wire

// >>> design/dar_shift.sv
// Output shift registers for both result lines.
// Assumes load, start and shift are one-cycle pulses on clk_i.
`timescale 1ns/1ps
`default_nettype none
module dar_shift (
  input wire logic clk_i,
  input wire logic rst_b_i,
  dar_sh_if.shf sh
);
  typedef struct packed {
    logic [31:0] sh_a;
    logic [15:0] sh_b;
    logic [5:0] cnt;
    logic out_a;
    logic out_b;
  } dar_sh_st_t;
  dar_sh_st_t s_q, s_d;
  logic [5:0] lim;

  // Line A carries both words in single-line mode
  always_comb begin
    s_d = s_q;
    lim = sh.single ? 6'(dar_pkg::SINGLE_BITS) : 6'(dar_pkg::DUAL_BITS);
    if (sh.load) begin
      s_d.sh_a = {sh.word_a, sh.word_b};
      s_d.sh_b = sh.word_b;
    end else if (sh.shift && s_q.cnt < lim) begin
      s_d.sh_a = {s_q.sh_a[30:0], 1'b0};
      s_d.sh_b = {s_q.sh_b[14:0], 1'b0};
      s_d.cnt = s_q.cnt + 6'd1;
    end
    if (sh.start) begin
      s_d.cnt = dar_pkg::CNT_RST;
    end
    // Past the last bit both lines hold low until the frame ends
    s_d.out_a = (s_d.cnt < lim) ? s_d.sh_a[31] : 1'b0;
    s_d.out_b = (s_d.cnt < lim && !sh.single) ? s_d.sh_b[15] : 1'b0;
  end

  // State register
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign sh.dout_a = s_q.out_a;
  assign sh.dout_b = s_q.out_b;

  chk_low_after_last: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    (s_q.cnt == 6'd16 && !sh.single) |-> (!sh.dout_a && !sh.dout_b))
    else $error("result lines not low after last bit");
  chk_load_both: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    sh.load |=> (s_q.sh_b == $past(sh.word_b) && s_q.sh_a[31:16] == $past(sh.word_a)))
    else $error("channels not loaded together");
  chk_next_bit: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    (sh.shift && !sh.load && !sh.start && s_q.cnt < 6'd15 && !sh.single) |=> sh.dout_b == $past(s_q.sh_b[14]))
    else $error("next lower bit not presented");
endmodule : dar_shift
`default_nettype wire

// >>> design/dar_top.sv
// Digital side of a two-channel simultaneous-sampling 16-bit converter.
// Assumes the host drives chip select and serial clock as asynchronous pins;
// the analog core is modelled by digitised input levels, config bits are ports.
//
// Summary of operation
// - One shared bit selects internal reference
// - Reference select resets to external, zero
// - Both channels sampled together, differential
// - Span bit doubles full-scale range
// - Input mode bit: single-ended or pseudo-differential
// - Format bit: straight binary or two's complement
// - Results are sixteen bits, range over 2^16
// - Straight binary saturates 0000 to FFFF
// - Two's complement spans 8000 to 7FFF
// - Dual-line mode: one channel per line
// - Select rise: tri-state, sample, convert
// - Select fall: drive MSB, clock fall shifts
// - After last fall (16th, or 32nd on line A single-line) lines stay low
`timescale 1ns/1ps
`default_nettype none
module dar_top #(
  parameter int LVL_W = dar_pkg::LVL_W
) (
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire logic cs_b_i,
  input wire logic sclk_i,
  input wire logic ref_source_bit_i,
  input wire logic [LVL_W-1:0] ref_level_code_a_i,
  input wire logic [LVL_W-1:0] ref_level_code_b_i,
  input wire logic span_bit_i,
  input wire logic neg_input_mode_bit_i,
  input wire logic twos_comp_bit_i,
  input wire logic lane_count_bit_i,
  input wire logic [16:0] pos_input_a_i,
  input wire logic [16:0] neg_input_a_i,
  input wire logic [16:0] pos_input_b_i,
  input wire logic [16:0] neg_input_b_i,
  output logic ref_int_en_o,
  output logic [LVL_W-1:0] ref_pin_a_level_o,
  output logic [LVL_W-1:0] ref_pin_b_level_o,
  output logic result_line_a_o,
  output logic result_line_a_oe_o,
  output logic result_line_b_o,
  output logic result_line_b_oe_o,
  output logic busy_o
);
  localparam int CONV_N = dar_pkg::CONV_CYC;

  typedef struct packed {
    logic cs_m;
    logic cs_s;
    logic cs_d;
    logic ck_m;
    logic ck_s;
    logic ck_d;
    logic [67:0] in_m;
    logic [67:0] in_s;
    dar_pkg::dar_state_t st;
    logic [5:0] cnt;
    logic [15:0] smp_a;
    logic [15:0] smp_b;
    logic load;
    logic oe;
    logic ref_int;
    logic [LVL_W-1:0] lvl_a;
    logic [LVL_W-1:0] lvl_b;
  } dar_st_t;

  dar_st_t s_q, s_d;
  logic cs_rise;
  logic cs_fall;
  logic ck_fall;
  logic [15:0] code_a;
  logic [15:0] code_b;
  dar_sh_if sh ();

  // Ideal transfer: difference, span scaling, offset, saturation, coding
  function automatic logic [15:0] conv_code(input logic [16:0] p, input logic [16:0] n,
                                            input logic span, input logic pd, input logic tc);
    logic signed [18:0] diff;
    logic [15:0] c;
    diff = $signed({2'b00, p}) - $signed({2'b00, n});
    if (span) begin
      diff = diff >>> 1;
    end
    if (pd) begin
      diff = diff + $signed({3'b000, dar_pkg::CODE_MID});
    end
    if (diff < 0) begin
      c = dar_pkg::CODE_MIN;
    end else if (diff > $signed({3'b000, dar_pkg::CODE_MAX})) begin
      c = dar_pkg::CODE_MAX;
    end else begin
      c = diff[15:0];
    end
    conv_code = tc ? (c ^ dar_pkg::CODE_MID) : c;
  endfunction : conv_code

  // Edges come from the second and third stages only
  assign cs_rise = s_q.cs_s && !s_q.cs_d;
  assign cs_fall = !s_q.cs_s && s_q.cs_d;
  assign ck_fall = !s_q.ck_s && s_q.ck_d;
  assign code_a = conv_code(s_q.in_s[67:51], s_q.in_s[50:34], span_bit_i, neg_input_mode_bit_i,
                            twos_comp_bit_i);
  assign code_b = conv_code(s_q.in_s[33:17], s_q.in_s[16:0], span_bit_i, neg_input_mode_bit_i,
                            twos_comp_bit_i);

  // Next state: synchronisers, sampling, conversion timer, line enables
  always_comb begin
    s_d = s_q;
    s_d.cs_m = cs_b_i;
    s_d.cs_s = s_q.cs_m;
    s_d.cs_d = s_q.cs_s;
    s_d.ck_m = sclk_i;
    s_d.ck_s = s_q.ck_m;
    s_d.ck_d = s_q.ck_s;
    s_d.in_m = {pos_input_a_i, neg_input_a_i, pos_input_b_i, neg_input_b_i};
    s_d.in_s = s_q.in_m;
    s_d.load = 1'b0;
    // Shared reference select; level codes only reach the pins when internal
    s_d.ref_int = ref_source_bit_i;
    s_d.lvl_a = ref_source_bit_i ? ref_level_code_a_i : '0;
    s_d.lvl_b = ref_source_bit_i ? ref_level_code_b_i : '0;
    if (cs_rise) begin
      s_d.oe = 1'b0;
    end else if (cs_fall) begin
      s_d.oe = 1'b1;
    end
    unique case (s_q.st)
      dar_pkg::DAR_IDLE: begin
        if (cs_rise) begin
          // Both channels captured in the same cycle
          s_d.smp_a = code_a;
          s_d.smp_b = code_b;
          s_d.cnt = 6'(CONV_N - 1);
          s_d.st = dar_pkg::DAR_CONV;
        end
      end
      dar_pkg::DAR_CONV: begin
        // Host holds off for the conversion time, so no frame restarts here
        if (s_q.cnt == dar_pkg::CNT_RST) begin
          s_d.load = 1'b1;
          s_d.st = dar_pkg::DAR_IDLE;
        end else begin
          s_d.cnt = s_q.cnt - 6'd1;
        end
      end
    endcase
  end

  // State register; pins idle high so synchronisers reset high
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      s_q <= '0;
      s_q.cs_m <= 1'b1;
      s_q.cs_s <= 1'b1;
      s_q.cs_d <= 1'b1;
      s_q.ck_m <= 1'b1;
      s_q.ck_s <= 1'b1;
      s_q.ck_d <= 1'b1;
      s_q.st <= dar_pkg::DAR_IDLE;
      s_q.ref_int <= dar_pkg::REF_SRC_RST;
    end else begin
      s_q <= s_d;
    end
  end

  // Shifter control; clock falls outside a frame are ignored
  assign sh.load = s_q.load;
  assign sh.start = cs_fall;
  assign sh.shift = ck_fall && !s_q.cs_s && s_q.oe;
  assign sh.single = lane_count_bit_i;
  assign sh.word_a = s_q.smp_a;
  assign sh.word_b = s_q.smp_b;

  dar_shift u_shift (
    .clk_i(clk_i),
    .rst_b_i(rst_b_i),
    .sh(sh)
  );

  // Outputs
  assign result_line_a_o = sh.dout_a;
  assign result_line_b_o = sh.dout_b;
  assign result_line_a_oe_o = s_q.oe;
  assign result_line_b_oe_o = s_q.oe;
  assign ref_int_en_o = s_q.ref_int;
  assign ref_pin_a_level_o = s_q.lvl_a;
  assign ref_pin_b_level_o = s_q.lvl_b;
  assign busy_o = (s_q.st == dar_pkg::DAR_CONV);

  sequence seq_sel_rise;
    cs_rise && s_q.st == dar_pkg::DAR_IDLE;
  endsequence
  sequence seq_conv_done;
    s_q.load && !busy_o;
  endsequence

  chk_tristate_rise: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    cs_rise |=> !result_line_a_oe_o && !result_line_b_oe_o)
    else $error("lines not released on select rise");
  chk_drive_fall: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    cs_fall |=> result_line_a_oe_o && result_line_b_oe_o)
    else $error("lines not driven on select fall");
  chk_conv_length: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    seq_sel_rise |=> busy_o [*1] ##(CONV_N) seq_conv_done)
    else $error("conversion length wrong");
  chk_ref_route: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    ##1 (ref_int_en_o == $past(ref_source_bit_i)) &&
        (ref_pin_a_level_o == ($past(ref_source_bit_i) ? $past(ref_level_code_a_i) : '0)))
    else $error("reference routing wrong");
  chk_sat_top: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    (seq_sel_rise and (!span_bit_i && !neg_input_mode_bit_i && !twos_comp_bit_i &&
      s_q.in_s[67:51] >= 17'h1_0000 && s_q.in_s[50:34] == 17'h0_0000)) |=> s_q.smp_a == 16'hFFFF)
    else $error("full scale not saturated");
  chk_twos_mid: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    (seq_sel_rise and (twos_comp_bit_i && neg_input_mode_bit_i &&
      s_q.in_s[33:17] == s_q.in_s[16:0])) |=> s_q.smp_b == 16'h0000)
    else $error("mid-scale two's complement wrong");
endmodule : dar_top
`default_nettype wire

// >>> sim/dar_host_model.sv
// Host side of the readout link: drives select and serial clock, samples both result lines.
// Assumes a dar_top on the far side; timing is in ns and unrelated to the system clock.
`timescale 1ns/1ps
`default_nettype none
module dar_host_model (
  output logic cs_b_o,
  output logic sclk_o,
  input wire logic line_a_i,
  input wire logic line_a_oe_i,
  input wire logic line_b_i,
  input wire logic line_b_oe_i
);
  // Link idles high; the clock stands still between frames
  initial begin
    cs_b_o = 1'b1;
    sclk_o = 1'b1;
  end

  // One frame: read n+2 bits, raise select, then hold both pins high
  task automatic frame(input int n, output logic [33:0] a, output logic [33:0] b, output logic off);
    a = '0;
    b = '0;
    cs_b_o = 1'b0;
    #203;
    for (int i = 0; i < n + 2; i++) begin
      // Released line reads as z so a stale value never passes
      a = {a[32:0], line_a_oe_i ? line_a_i : 1'bz};
      b = {b[32:0], line_b_oe_i ? line_b_i : 1'bz};
      sclk_o = 1'b0;
      #100;
      sclk_o = 1'b1;
      #100;
    end
    cs_b_o = 1'b1;
    #250;
    off = !line_a_oe_i && !line_b_oe_i;
    #625;
  endtask : frame
endmodule : dar_host_model
`default_nettype wire

// >>> sim/dar_top_tb_top.sv
// Self-checking bench for dar_top: random and corner samples read back over the link.
// Assumes dar_pkg and the host model are compiled first.
`timescale 1ns/1ps
`default_nettype none
module dar_top_tb_top;
  logic clk_i = 1'b0;
  logic rst_b_i = 1'b0;
  logic cs_b, sclk, ref_src, span, pd, tc, lane, ref_en, la, la_oe, lb, lb_oe, off, busy;
  logic [dar_pkg::LVL_W-1:0] lvl_a, lvl_b, pin_a, pin_b;
  logic [16:0] pa, na, pb, nb;
  logic [33:0] ga, gb;
  logic [15:0] ea, eb;
  logic [31:0] r, r2;
  int mismatches = 0;
  int samples_checked = 0;
  int cyc = 0;
  int n;

  always #12.5 clk_i = ~clk_i;

  dar_top #(.LVL_W(dar_pkg::LVL_W)) dar_top_i (.clk_i(clk_i), .rst_b_i(rst_b_i), .cs_b_i(cs_b),
    .sclk_i(sclk), .ref_source_bit_i(ref_src), .ref_level_code_a_i(lvl_a), .ref_level_code_b_i(lvl_b),
    .span_bit_i(span), .neg_input_mode_bit_i(pd), .twos_comp_bit_i(tc), .lane_count_bit_i(lane),
    .pos_input_a_i(pa), .neg_input_a_i(na), .pos_input_b_i(pb), .neg_input_b_i(nb),
    .ref_int_en_o(ref_en), .ref_pin_a_level_o(pin_a), .ref_pin_b_level_o(pin_b),
    .result_line_a_o(la), .result_line_a_oe_o(la_oe), .result_line_b_o(lb),
    .result_line_b_oe_o(lb_oe), .busy_o(busy));

  dar_host_model dar_host_model_i (.cs_b_o(cs_b), .sclk_o(sclk), .line_a_i(la), .line_a_oe_i(la_oe),
    .line_b_i(lb), .line_b_oe_i(lb_oe));

  // Reference code model: ideal transfer, clamped, optional sign flip
  function automatic logic [15:0] code(input int p, input int m, input logic s, input logic d,
    input logic t);
    int v;
    v = p - m;
    if (s) v = v / 2;
    if (d) v = v + 32768;
    if (v < 0) v = 0;
    if (v > 65535) v = 65535;
    return 16'(v) ^ (t ? 16'h8000 : 16'h0000);
  endfunction : code

  task automatic check(input logic [33:0] got, input logic [33:0] exp, input string what);
    samples_checked++;
    if (got !== exp) begin
      mismatches++;
      $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask : check

  task automatic stop_test();
    $display("mismatches %0d samples_checked %0d", mismatches, samples_checked);
    if (mismatches == 0 && samples_checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : stop_test

  // Hang guard, about twice the expected run
  always @(posedge clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      mismatches++;
      stop_test();
    end
  end

  // Main sequence: each frame reads the previous sample and takes a new one
  initial begin
    {ref_src, span, pd, tc, lane} = 5'h00;
    {lvl_a, lvl_b} = '0;
    {pa, na, pb, nb} = '0;
    {ea, eb} = '0;
    r = $urandom(32'he368_86ad);
    repeat (20) @(posedge clk_i);
    #2 rst_b_i = 1'b1;
    @(posedge clk_i);
    #2;
    check({31'h0, ref_en, la_oe, lb_oe}, 34'h0, "after reset");
    for (int k = 0; k < 48; k++) begin
      @(posedge clk_i);
      #2;
      r = $urandom;
      r2 = $urandom;
      {ref_src, tc, pd, span} = (k < 16) ? {1'b0, 3'(k >> 1)} : r[3:0];
      lane = (k >= 16) && (r[5:4] == 2'b11);
      lvl_a = 10'h1ff;
      lvl_b = r[29:20];
      pa = (k < 16) ? (k[0] ? 17'h1_fffe : 17'h0_0000) : {r[22:7], 1'b0};
      na = (k < 16) ? (k[0] ? 17'h0_0000 : 17'h0_0100) : {4'h0, r[31:20], 1'b0};
      pb = (k < 16) ? (k[0] ? 17'h0_0000 : 17'h1_fffe) : {r2[15:0], 1'b0};
      nb = (k < 16) ? 17'h0_0000 : {4'h0, r2[27:16], 1'b0};
      n = lane ? 32 : 16;
      dar_host_model_i.frame(n, ga, gb, off);
      check(ga, lane ? {ea, eb, 2'b00} : {16'h0000, ea, 2'b00}, "line a");
      check(gb, lane ? 34'h0 : {16'h0000, eb, 2'b00}, "line b");
      check({33'h0, off}, 34'h1, "lines released");
      check({23'h0, ref_en, pin_a}, {23'h0, ref_src, ref_src ? lvl_a : 10'h000}, "ref a");
      check({24'h0, pin_b}, {24'h0, ref_src ? lvl_b : 10'h000}, "ref b");
      check({33'h0, busy}, 34'h0, "conversion finished");
      ea = code(pa, na, span, pd, tc);
      eb = code(pb, nb, span, pd, tc);
    end
    stop_test();
  end
endmodule : dar_top_tb_top
`default_nettype wire
